// ===== logic/t1hdl_pkg.sv
/*
  Constants, register map and carrier types of the receive data-link unit.
  Assumes a single sys_clk domain and a byte-wide register port.
*/
`default_nettype none

package t1hdl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [ADDR_W-1:0] OFS_DL_SEL = 8'h0D;
  localparam logic [ADDR_W-1:0] OFS_RX_CTL = 8'h54;
  localparam logic [ADDR_W-1:0] OFS_INT_CTL = 8'h55;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h56;
  localparam logic [ADDR_W-1:0] OFS_RX_DATA = 8'h57;
  localparam logic [ADDR_W-1:0] OFS_ADDR_PRI = 8'h58;
  localparam logic [ADDR_W-1:0] OFS_ADDR_SEC = 8'h59;
  localparam logic [ADDR_W-1:0] OFS_L2_POS = 8'h70;
  localparam logic [ADDR_W-1:0] OFS_L2_MASK = 8'h71;

  // field positions
  localparam int BIT_PATH_SEL = 3;
  localparam int SEL_HI = 7;
  localparam int SEL_LO = 6;
  localparam int POS_EVEN = 7;
  localparam int POS_ODD = 6;
  localparam int CHAN_HI = 4;
  localparam int CTL_EN = 0;
  localparam int CTL_MM = 2;
  localparam int CTL_MEN = 3;
  localparam int INT_EN = 7;
  localparam int THR_HI = 6;

  // link choice codes
  localparam logic [1:0] LINK_ONE = 2'h0;
  localparam logic [1:0] LINK_TWO = 2'h1;

  // reset values
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;

  // deframer constants
  localparam logic [2:0] ONES_STUFF = 3'h5;
  localparam logic [2:0] ONES_FLAG = 3'h6;
  localparam logic [2:0] ONES_ABORT = 3'h7;
  localparam logic [2:0] BITS_AT_FLAG = 3'h6;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] MIN_FRAME_BYTES = 3'h4;
  localparam logic [2:0] BYTE_CNT_MAX = 3'h7;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_GOOD = 16'hF0B8;
  localparam logic [7:0] MATCH_MASK_HI = 8'hFC;

  // receive FIFO
  localparam int FIFO_AW = 7;
  localparam int FIFO_DEPTH = 1 << FIFO_AW;
  localparam logic [FIFO_AW:0] FIFO_FULL = 8'h80;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } t1hdl_busreq_t;

  // one received line bit with its position in the frame
  typedef struct packed {
    logic valid;
    logic data;
    logic fBit;
    logic frameOdd;
    logic [4:0] channel;
    logic [2:0] bitPos;
  } t1hdl_rxbit_t;

  typedef struct packed {
    logic bad;
    logic eop;
    logic [DATA_W-1:0] data;
  } t1hdl_entry_t;

  typedef struct packed {
    logic [DATA_W-1:0] dlSel;
    logic [DATA_W-1:0] rxCtl;
    logic [DATA_W-1:0] intCtl;
    logic [DATA_W-1:0] pos;
    logic [DATA_W-1:0] mask;
    logic [DATA_W-1:0] addrPri;
    logic [DATA_W-1:0] addrSec;
  } t1hdl_regs_t;

endpackage

`default_nettype wire

// ===== logic/t1hdl_rx.sv
/*
  Receive HDLC data-link unit of one T1/J1 framer: link selection, bit
  extraction, HDLC deframing, address match, receive FIFO, fill interrupt.
  Assumes rxBit and esfMode come from framer logic on sys_clk, and a host
  register port with read data one cycle after the read strobe.
*/
// Overview of operation
// R1: extraction runs only while the framer is in extended superframe format.
// R2: path select bit 3 clear routes link position fields to receive path.
// R3: link choice bits 7..6 pick link one (00) or link two (01).
// R4: link one takes only the framing bit of odd frames.
// R5: link two takes chosen frames, channel and bits.
// R6: position register: even enable b7, odd enable b6, channel b4..0.
// R7: eight-bit mask selects which channel bits feed the receiver.
// R8: receiver runs only while control bit 0 is set.
// R9: match enable b3 and match mode b2 choose address matching.
// R10: host loads primary and secondary match addresses after enabling.
// R11: nonzero threshold: status bit 0 sets when FIFO count exceeds it.
// R12: fill status stays set until the FIFO is empty.
// R13: interrupt enable b7 gates fill status onto active-low pin.
// R14: host reads interrupt identification registers first on an interrupt.
// R15: data may be collected by polling or by interrupt.
// R16: polling uses the interrupt service procedure from a local timer.
// R17: host reads status, then pops data bytes until a packet completes.
// R18: deframing removes flags, deletes stuffed zeros, checks the FCS.
`timescale 1ns/1ps
`default_nettype none

module t1hdl_rx
  import t1hdl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire t1hdl_busreq_t busReq,
  output logic [DATA_W-1:0] regRdData,
  input wire t1hdl_rxbit_t rxBit,
  input wire logic esfMode,
  output logic intN
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    t1hdl_regs_t regs;
    logic [DATA_W-1:0] rdData;
    logic intN;
    // deframer
    logic inFrame;
    logic discard;
    logic [2:0] ones;
    logic [2:0] bitCnt;
    logic [2:0] byteCnt;
    logic [7:0] shift;
    logic [15:0] crc;
    logic [15:0] crcAtByte;
    logic pendValid;
    logic [7:0] pend;
    // FIFO and status
    t1hdl_entry_t [FIFO_DEPTH-1:0] mem;
    logic [FIFO_AW-1:0] wrPtr;
    logic [FIFO_AW-1:0] rdPtr;
    logic [FIFO_AW:0] count;
    logic fillInt;
    logic overrun;
  } t1hdl_state_t;

  localparam t1hdl_state_t STATE_RESET = '{
    regs: '{default: REG_RESET},
    rdData: REG_RESET,
    intN: 1'b1,
    crc: CRC_INIT,
    crcAtByte: CRC_INIT,
    default: '0
  };

  t1hdl_state_t q;
  t1hdl_state_t d;

  function automatic logic [15:0] crcStep(input logic [15:0] c,
                                          input logic b);
    logic [15:0] s;
    s = {1'b0, c[15:1]};
    if (c[0] ^ b) begin
      s = s ^ CRC_POLY;
    end
    return s;
  endfunction

  function automatic logic addrHit(input logic [7:0] a,
                                   input logic [7:0] pri,
                                   input logic [7:0] sec,
                                   input logic mm);
    logic [7:0] m;
    m = mm ? MATCH_MASK_HI : 8'hFF;
    return ((a & m) == (pri & m)) || ((a & m) == (sec & m));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic enabled;
  logic onLinkOne;
  logic onLinkTwo;
  logic frameOk;
  logic bitEvt;
  logic doShift;
  logic shBit;
  logic [7:0] newByte;
  logic [15:0] crcNext;
  logic pushReq;
  t1hdl_entry_t pushEntry;
  logic doPush;
  logic popReq;
  logic statRd;
  logic [FIFO_AW:0] cntNext;
  logic [1:0] choice;
  logic [2:0] maskIdx;
  t1hdl_entry_t head;

  always_comb begin
    d = q;
    enabled = q.regs.rxCtl[CTL_EN];                               // R8
    choice = q.regs.dlSel[SEL_HI:SEL_LO];
    maskIdx = BIT_LAST - rxBit.bitPos;
    onLinkOne = (choice == LINK_ONE) && rxBit.fBit
                && rxBit.frameOdd;                                // R3 R4
    frameOk = rxBit.frameOdd ? q.regs.pos[POS_ODD]
                             : q.regs.pos[POS_EVEN];              // R6
    onLinkTwo = (choice == LINK_TWO) && !q.regs.dlSel[BIT_PATH_SEL]
                && !rxBit.fBit && frameOk
                && (rxBit.channel == q.regs.pos[CHAN_HI:0])
                && q.regs.mask[maskIdx];                          // R2 R5 R7
    bitEvt = enabled && esfMode && rxBit.valid
             && (onLinkOne || onLinkTwo);                         // R1
    doShift = 1'b0;
    shBit = 1'b0;
    pushReq = 1'b0;
    pushEntry = '0;
    newByte = {shBit, q.shift[7:1]};
    crcNext = q.crc;

    // flag hunt, zero deletion and abort
    if (!enabled) begin
      d.inFrame = 1'b0;
      d.pendValid = 1'b0;
      d.ones = '0;
    end else if (bitEvt) begin
      if (rxBit.data) begin
        if (q.ones == ONES_FLAG) begin
          if (q.inFrame && q.pendValid && !q.discard) begin
            pushReq = 1'b1;
            pushEntry = '{bad: 1'b1, eop: 1'b1, data: q.pend};
          end
          d.inFrame = 1'b0;
          d.pendValid = 1'b0;
          d.ones = ONES_ABORT;
        end else if (q.ones != ONES_ABORT) begin
          d.ones = q.ones + 3'h1;
          doShift = (q.ones != ONES_STUFF);                       // R18
          shBit = 1'b1;
        end
      end else begin
        d.ones = '0;
        if (q.ones == ONES_FLAG) begin                            // R18
          if (q.inFrame && q.pendValid && !q.discard) begin
            pushReq = 1'b1;
            pushEntry.eop = 1'b1;
            pushEntry.data = q.pend;
            pushEntry.bad = (q.bitCnt != BITS_AT_FLAG)
                            || (q.crcAtByte != CRC_GOOD)
                            || (q.byteCnt < MIN_FRAME_BYTES);     // R18
          end
          d.inFrame = 1'b1;
          d.discard = 1'b0;
          d.pendValid = 1'b0;
          d.bitCnt = '0;
          d.byteCnt = '0;
          d.crc = CRC_INIT;
          d.crcAtByte = CRC_INIT;
        end else begin
          doShift = (q.ones != ONES_STUFF);                       // R18
        end
      end
    end

    // byte assembly, lsb first; last byte held back to mark the packet end
    if (doShift && q.inFrame) begin
      newByte = {shBit, q.shift[7:1]};
      crcNext = crcStep(q.crc, shBit);
      d.shift = newByte;
      d.crc = crcNext;
      d.bitCnt = q.bitCnt + 3'h1;
      if (q.bitCnt == BIT_LAST) begin
        d.crcAtByte = crcNext;
        if (q.byteCnt != BYTE_CNT_MAX) begin
          d.byteCnt = q.byteCnt + 3'h1;
        end
        if ((q.byteCnt == '0) && q.regs.rxCtl[CTL_MEN]
            && !addrHit(newByte, q.regs.addrPri, q.regs.addrSec,
                        q.regs.rxCtl[CTL_MM])) begin              // R9
          d.discard = 1'b1;
        end else if (!q.discard) begin
          if (q.pendValid) begin
            pushReq = 1'b1;
            pushEntry = '{bad: 1'b0, eop: 1'b0, data: q.pend};
          end
          d.pend = newByte;
          d.pendValid = 1'b1;
        end
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // receive FIFO
    head = q.mem[q.rdPtr];
    popReq = busReq.rd && (busReq.addr == OFS_RX_DATA)
             && (q.count != '0);                                  // R17
    statRd = busReq.rd && (busReq.addr == OFS_STATUS);
    doPush = pushReq && (q.count != FIFO_FULL);
    if (doPush) begin
      d.mem[q.wrPtr] = pushEntry;
      d.wrPtr = q.wrPtr + 1'b1;
    end
    if (popReq) begin
      d.rdPtr = q.rdPtr + 1'b1;
    end
    cntNext = q.count;
    if (doPush && !popReq) begin
      cntNext = q.count + 1'b1;
    end else if (!doPush && popReq) begin
      cntNext = q.count - 1'b1;
    end
    d.count = cntNext;
    // lost byte flag: a new loss wins over the clearing status read
    d.overrun = (q.overrun && !statRd) || (pushReq && !doPush);

    // fill status, held until the FIFO drains
    d.fillInt = (q.fillInt && (cntNext != '0))                    // R12
                || ((q.regs.intCtl[THR_HI:0] != '0)
                    && (cntNext > {1'b0, q.regs.intCtl[THR_HI:0]})); // R11
    d.intN = !(q.regs.intCtl[INT_EN] && d.fillInt);               // R13 R15

    ////////////////////////////////////////////////////////////////////////
    // register port
    if (busReq.wr) begin
      unique case (busReq.addr)
        OFS_DL_SEL: d.regs.dlSel = busReq.wdata;
        OFS_RX_CTL: d.regs.rxCtl = busReq.wdata;
        OFS_INT_CTL: d.regs.intCtl = busReq.wdata;
        OFS_ADDR_PRI: d.regs.addrPri = busReq.wdata;
        OFS_ADDR_SEC: d.regs.addrSec = busReq.wdata;
        OFS_L2_POS: d.regs.pos = busReq.wdata;
        OFS_L2_MASK: d.regs.mask = busReq.wdata;
        default: ;
      endcase
    end
    d.rdData = REG_RESET;
    if (busReq.rd) begin
      unique case (busReq.addr)
        OFS_DL_SEL: d.rdData = q.regs.dlSel;
        OFS_RX_CTL: d.rdData = q.regs.rxCtl;
        OFS_INT_CTL: d.rdData = q.regs.intCtl;
        OFS_STATUS: d.rdData = {3'h0, q.overrun,
                                head.bad && (q.count != '0),
                                head.eop && (q.count != '0),
                                q.count == '0, q.fillInt};        // R15 R17
        OFS_RX_DATA: d.rdData = popReq ? head.data : REG_RESET;   // R17
        OFS_ADDR_PRI: d.rdData = q.regs.addrPri;
        OFS_ADDR_SEC: d.rdData = q.regs.addrSec;
        OFS_L2_POS: d.rdData = q.regs.pos;
        OFS_L2_MASK: d.rdData = q.regs.mask;
        default: d.rdData = REG_RESET;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q <= STATE_RESET;
    end else if (clkEn) begin
      q <= d;
    end
  end

  assign regRdData = q.rdData;
  assign intN = q.intN;

endmodule // t1hdl_rx

`default_nettype wire

// ===== tb/t1hdl_rx_asserts.sv
/* Port checker of the receive data-link unit.
   Assumes one sys_clk domain, bound to t1hdl_rx in the bench top. */
`timescale 1ns/1ps
`default_nettype none

module t1hdl_rx_asserts
  import t1hdl_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire t1hdl_busreq_t busReq,
  input wire logic [DATA_W-1:0] regRdData,
  input wire t1hdl_rxbit_t rxBit,
  input wire logic esfMode,
  input wire logic intN
);
  logic [DATA_W-1:0] intCtl_q;

  // shadow of the interrupt control register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      intCtl_q <= REG_RESET;
    end else if (clkEn && busReq.wr && busReq.addr == OFS_INT_CTL) begin
      intCtl_q <= busReq.wdata;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_rdIdle;
    $past(clkEn) && !$past(busReq.rd) |-> regRdData == 8'h00;
  endproperty
  a_rdIdle: assert property (p_rdIdle)
    else $error("read data outside read slot");
  property p_unmapped;
    clkEn && busReq.rd && busReq.addr == 8'h00 |=> regRdData == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_rdInt;
    clkEn && busReq.rd && busReq.addr == OFS_INT_CTL
      |=> regRdData == $past(intCtl_q);
  endproperty
  a_rdInt: assert property (p_rdInt)
    else $error("interrupt control readback");
  property p_rdPos;
    busReq.wr && busReq.addr == OFS_L2_POS ##1 !busReq.wr ##1
      busReq.rd && busReq.addr == OFS_L2_POS
      |=> regRdData == $past(busReq.wdata, 3);
  endproperty
  a_rdPos: assert property (p_rdPos)
    else $error("position readback");
  property p_gate;
    !$past(intCtl_q[INT_EN]) |-> intN;
  endproperty
  a_gate: assert property (p_gate)
    else $error("pin low with enable clear");
  property p_thr;
    $fell(intN) && $past(intCtl_q[INT_EN], 2)
      |-> $past(intCtl_q[THR_HI:0]) != 7'h00;
  endproperty
  a_thr: assert property (p_thr)
    else $error("interrupt with zero threshold");
  property p_rise;
    $rose(intN) |-> $past(busReq.rd) || $past(busReq.rd, 2)
      || $past(busReq.wr) || $past(busReq.wr, 2);
  endproperty
  a_rise: assert property (p_rise)
    else $error("interrupt dropped without host access");
  property p_esf;
    (!esfMode && !busReq.wr && !busReq.rd) [*5] |-> $stable(intN);
  endproperty
  a_esf: assert property (p_esf)
    else $error("interrupt moved outside extended superframe");
endmodule // t1hdl_rx_asserts

`default_nettype wire

// ===== tb/t1hdl_link_model.sv
/* Framer side model: HDLC octets as line bits on channel 20, frames
   alternating every eight line bits, or on odd-frame framing bits while fLink is set.
   Assumes the bench calls octet(). */
`timescale 1ns/1ps
`default_nettype none

module t1hdl_link_model
  import t1hdl_pkg::*;
(
  input wire logic sys_clk,
  output var t1hdl_rxbit_t rxBit
);
  logic [2:0] ones = 3'h0;
  logic [2:0] pos = 3'h0;
  logic odd = 1'b0;
  logic fLink = 1'b0;

  initial rxBit = '0;

  // data flips once valid drops so stale bits cannot pass
  task automatic slot(input logic b, input logic f, input logic o,
                      input logic [4:0] ch);
    @(posedge sys_clk);
    rxBit <= '{1'b1, b, f, o, ch, pos};
    @(posedge sys_clk);
    rxBit <= '{1'b0, ~b, f, o, ch, pos};
  endtask

  // framing-bit mode: even-frame framing bit carries a decoy value
  task automatic line(input logic b);
    if (fLink) begin
      slot(b, 1'b1, 1'b1, 5'h00);
      slot(~b, 1'b1, 1'b0, 5'h00);
    end else begin
      slot(b, 1'b0, odd, 5'h14);
      pos = pos + 3'h1;
      if (pos == 3'h0) begin
        odd = ~odd;
        slot(~b, 1'b0, odd, 5'h13);
      end
    end
  endtask

  task automatic octet(input logic [7:0] v, input logic raw);
    for (int i = 0; i < 8; i++) begin
      line(v[i]);
      ones = (raw || !v[i]) ? 3'h0 : ones + 3'h1;
      if (ones == ONES_STUFF) begin
        line(1'b0);
        ones = 3'h0;
      end
    end
  endtask
endmodule // t1hdl_link_model

`default_nettype wire

// ===== tb/t1hdl_rx_tb.sv
/* Self-checking bench of the receive data-link unit.
   Assumes the link model and the port checker beside it. */
`timescale 1ns/1ps
`default_nettype none

module t1hdl_rx_tb import t1hdl_pkg::*; ;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  t1hdl_busreq_t busReq = '0;
  t1hdl_rxbit_t rxBit;
  logic esfMode = 1'b1;
  logic clkEn = 1'b1;
  logic [DATA_W-1:0] regRdData;
  logic intN;
  int errorCnt = 0;
  int comparisons = 0;
  int cyc = 0;
  logic [15:0] fcs;

  always #2.5 sys_clk = ~sys_clk;

  t1hdl_rx i_t1hdl_rx (.sys_clk(sys_clk), .rst(rst), .clkEn(clkEn),
    .busReq(busReq), .regRdData(regRdData), .rxBit(rxBit),
    .esfMode(esfMode), .intN(intN));
  t1hdl_link_model i_t1hdl_link_model (.sys_clk(sys_clk), .rxBit(rxBit));

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, errorCnt);
    if (errorCnt == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      errorCnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic put(input logic w, input logic [7:0] a, d,
                     output logic [7:0] q);
    busReq <= '{w, ~w, a, d};
    @(posedge sys_clk);
    busReq <= '0;
    #1 q = regRdData;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] a, d);
    logic [7:0] q;
    put(1'b1, a, d, q);
  endtask

  task automatic rc(input string nm, input logic [7:0] a, e);
    logic [7:0] q;
    put(1'b0, a, 8'h00, q);
    chk(nm, q, e);
  endtask

  function automatic logic [15:0] crc(input logic [15:0] c, input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      c = (c[0] ^ b[i]) ? (c >> 1) ^ CRC_POLY : c >> 1;
    end
    return c;
  endfunction

  task automatic frame(input logic [7:0] a, b);
    logic [7:0] v[6];
    fcs = ~crc(crc(CRC_INIT, a), b);
    v = '{8'h7E, a, b, fcs[7:0], fcs[15:8], 8'h7E};
    foreach (v[i]) i_t1hdl_link_model.octet(v[i], i == 0 || i == 5);
    repeat (6) @(posedge sys_clk);
  endtask

  // polled collection of one four-byte frame, threshold 2
  task automatic take(input logic [7:0] a, b);
    logic [7:0] e[4];
    e = '{a, b, fcs[7:0], fcs[15:8]};
    rc("status", OFS_STATUS, 8'h01);
    chk("intN", {7'h00, intN}, 8'h00);
    for (int i = 0; i < 4; i++) begin
      if (i == 3) rc("status eop", OFS_STATUS, 8'h05);
      rc("data", OFS_RX_DATA, e[i]);
      if (i == 1) chk("intN", {7'h00, intN}, 8'h00);
    end
    rc("status", OFS_STATUS, 8'h02);
    chk("intN", {7'h00, intN}, 8'h01);
  endtask

  task automatic test_regs;
    logic [7:0] rw[7];
    rw = '{OFS_DL_SEL, OFS_RX_CTL, OFS_INT_CTL, OFS_ADDR_PRI, OFS_ADDR_SEC,
           OFS_L2_POS, OFS_L2_MASK};
    foreach (rw[i]) begin
      rc("reset", rw[i], REG_RESET);
      wr(rw[i], 8'h5A ^ 8'(i));
      rc("readback", rw[i], 8'h5A ^ 8'(i));
      wr(rw[i], REG_RESET);
    end
    wr(OFS_STATUS, 8'hFF);
    rc("status ro", OFS_STATUS, 8'h02);
    wr(8'h00, 8'hFF);
    rc("unmapped", 8'h00, 8'h00);
  endtask

  task automatic test_refuse;
    logic [7:0] ra[6], bad[6], good[6];
    ra = '{OFS_RX_CTL, OFS_DL_SEL, OFS_DL_SEL, OFS_DL_SEL, OFS_L2_POS,
           OFS_L2_MASK};
    bad = '{8'h00, 8'h00, 8'h48, 8'h80, 8'h14, 8'h00};
    good = '{8'h01, 8'h40, 8'h40, 8'h40, 8'hD4, 8'hFF};
    for (int i = 0; i < 7; i++) begin
      if (i < 6) wr(ra[i], bad[i]); else esfMode <= 1'b0;
      frame(8'hC3, 8'h3C);
      rc("refused", OFS_STATUS, 8'h02);
      if (i < 6) wr(ra[i], good[i]); else esfMode <= 1'b1;
    end
  endtask

  // bad FCS marks the last entry; pin stays high with its enable clear
  task automatic test_bad;
    logic [7:0] v[6];
    wr(OFS_INT_CTL, 8'h02);
    fcs = crc(crc(CRC_INIT, 8'h21), 8'h43);
    v = '{8'h7E, 8'h21, 8'h43, fcs[7:0], fcs[15:8], 8'h7E};
    foreach (v[i]) i_t1hdl_link_model.octet(v[i], i == 0 || i == 5);
    repeat (6) @(posedge sys_clk);
    chk("intN gated", {7'h00, intN}, 8'h01);
    for (int i = 0; i < 3; i++) rc("bad data", OFS_RX_DATA, v[i + 1]);
    rc("status bad", OFS_STATUS, 8'h0D);
    rc("bad data", OFS_RX_DATA, fcs[15:8]);
    rc("status", OFS_STATUS, 8'h02);
    wr(OFS_INT_CTL, 8'h82);
  endtask

  // clock enable low freezes the port; a mid-run reset clears the registers
  task automatic test_hold;
    wr(OFS_ADDR_SEC, 8'h3C);
    clkEn <= 1'b0;
    wr(OFS_ADDR_SEC, 8'hA5);
    rc("frozen read", OFS_ADDR_SEC, 8'h00);
    clkEn <= 1'b1;
    rc("frozen write", OFS_ADDR_SEC, 8'h3C);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rc("reset sec", OFS_ADDR_SEC, REG_RESET);
    rc("reset sel", OFS_DL_SEL, REG_RESET);
    chk("intN reset", {7'h00, intN}, 8'h01);
  endtask

  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    test_regs();
    wr(OFS_DL_SEL, 8'h40);
    wr(OFS_L2_POS, 8'hD4);
    wr(OFS_L2_MASK, 8'hFF);
    wr(OFS_RX_CTL, 8'h01);
    wr(OFS_INT_CTL, 8'h82);
    frame(8'hA1, 8'hFF);
    take(8'hA1, 8'hFF);
    test_bad();
    test_refuse();
    wr(OFS_RX_CTL, 8'h09);
    wr(OFS_ADDR_PRI, 8'h13);
    wr(OFS_ADDR_SEC, 8'hFF);
    frame(8'h12, 8'h34);
    rc("no match", OFS_STATUS, 8'h02);
    frame(8'hFF, 8'h34);
    take(8'hFF, 8'h34);
    wr(OFS_RX_CTL, 8'h0D);
    wr(OFS_ADDR_PRI, 8'h10);
    frame(8'h13, 8'h56);
    take(8'h13, 8'h56);
    wr(OFS_RX_CTL, 8'h01);
    wr(OFS_DL_SEL, 8'h00);
    i_t1hdl_link_model.fLink = 1'b1;
    frame(8'h5C, 8'h77);
    take(8'h5C, 8'h77);
    test_hold();
    wrap_up();
  end

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errorCnt++;
      wrap_up();
    end
  end
endmodule // t1hdl_rx_tb

bind t1hdl_rx t1hdl_rx_asserts i_t1hdl_rx_asserts (.sys_clk(sys_clk),
  .rst(rst), .clkEn(clkEn), .busReq(busReq), .regRdData(regRdData),
  .rxBit(rxBit), .esfMode(esfMode), .intN(intN));

`default_nettype wire
